/* peci_pkg.sv */
// constants, register map and helpers for the pin edge change interrupt block
package peci_pkg;

   localparam int          NUM_PORTS    = 4;
   localparam int          PORT_W       = 8;
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;

   // implemented bits of each port, port n in byte n; the fourth port has bit 3 only
   localparam logic [31:0] IMPL_MASKS   = 32'h08FF_FFFF;

   // per-port register block: base is port index times 16 bytes
   localparam logic [3:0]  OFS_RISE     = 4'h0;
   localparam logic [3:0]  OFS_FALL     = 4'h4;
   localparam logic [3:0]  OFS_FLAGS    = 4'h8;

   localparam logic [7:0]  ADDR_CTRL    = 8'h40;
   localparam logic [7:0]  ADDR_STATUS  = 8'h44;
   localparam logic [7:0]  ADDR_MASK    = 8'h48;

   // control register fields
   localparam int          CTRL_MASTER  = 0;
   localparam int          CTRL_SUMMARY = 1;

   // interrupt status and mask fields
   localparam int          EV_EDGE      = 0;
   localparam int          EV_WAKE      = 1;
   localparam int          EV_W         = 2;

   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [1:0]  RST_EV       = 2'h0;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;

   // cycles before the synchronised sample is trusted after reset
   localparam logic [1:0]  PRIME_CYCLES = 2'h2;

   function automatic logic [7:0] reg_addr(input logic [1:0] port, input logic [3:0] ofs);
      reg_addr = {2'h0, port, ofs};
   endfunction

   function automatic logic [7:0] impl_mask(input logic [1:0] port);
      impl_mask = IMPL_MASKS[{port, 3'h0} +: 8];
   endfunction

endpackage

/* peci_port_if.sv */
// per-port signal bundle between the register file and the flag bank
`timescale 1ns/10ps
interface peci_port_if;
   logic [7:0] rise_en;
   logic [7:0] fall_en;
   logic [7:0] rise_det;
   logic [7:0] fall_det;
   logic       flag_wr;
   logic [7:0] flag_wdata;
   logic [7:0] flags;
   logic       hit_any;

   modport regs (
      output rise_en,
      output fall_en,
      output flag_wr,
      output flag_wdata,
      input  flags,
      input  hit_any
   );

   modport bank (
      input  rise_en,
      input  fall_en,
      input  rise_det,
      input  fall_det,
      input  flag_wr,
      input  flag_wdata,
      output flags,
      output hit_any
   );
endinterface

/* peci_edge_detect.sv */
// pin synchroniser and rising/falling edge detector for one 8-bit port
`timescale 1ns/10ps
module peci_edge_detect (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] pins,
   output logic      [7:0] rise_o,
   output logic      [7:0] fall_o
);
   logic [7:0] meta_q;
   logic [7:0] sync_q;
   logic [7:0] prev_q;
   logic [1:0] prime_q;
   logic       primed_w;

   // no edges for two cycles after reset, but prev_q still holds zero then, so a high pin at reset is seen as a rising edge
   assign primed_w = (prime_q == peci_pkg::PRIME_CYCLES);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q  <= peci_pkg::RST_BYTE;
         sync_q  <= peci_pkg::RST_BYTE;
         prev_q  <= peci_pkg::RST_BYTE;
         prime_q <= 2'h0;
      end
      else
      begin
         meta_q  <= pins;
         sync_q  <= meta_q;
         prev_q  <= sync_q;
         if (!primed_w)
            prime_q <= prime_q + 2'h1;
      end
   end

   assign rise_o = primed_w ? (sync_q & ~prev_q) : 8'h00;
   assign fall_o = primed_w ? (~sync_q & prev_q) : 8'h00;
endmodule

/* peci_flag_bank.sv */
// sticky per-pin change flags of one port
`timescale 1ns/10ps
module peci_flag_bank (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] impl,
   peci_port_if.bank       pif
);
   logic [7:0] hit_w;
   logic [7:0] flags_d;
   logic [7:0] flags_q;

   // each polarity has its own enable, both may be set together
   assign hit_w   = impl & ((pif.rise_det & pif.rise_en) | (pif.fall_det & pif.fall_en));
   // hardware set is ORed last so an edge during a clearing write survives
   assign flags_d = impl & ((pif.flag_wr ? pif.flag_wdata : flags_q) | hit_w);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flags_q <= peci_pkg::RST_BYTE;
      else
         flags_q <= flags_d;
   end

   assign pif.flags   = flags_q;
   assign pif.hit_any = |hit_w;
endmodule

/* peci_top.sv */
// pin edge change interrupt controller with APB register access
//
// Summary of operation
// - every pin of every port has its own edge detection and can request an interrupt alone or with others.
// - with the master enable clear, edges are still detected and flags still set, but change_irq is not raised; irq still follows status and mask.
// - a set bit in the rising enable register arms that pin's rising-edge detector.
// - a set bit in the falling enable register arms that pin's falling-edge detector, independent of the rising one.
// - with both enables set a pin catches edges of both polarities.
// - an enabled edge sets the pin's flag and, with the master enable set, raises the request.
// - the summary flag is read-only and is the OR of all pin flags of all ports.
// - software clears flags by writing zeros, but an edge seen during that write leaves the flag set.
// - a detected change wakes the device from sleep whenever the master enable is set.
// - flags for edges seen in sleep are updated no later than the wake indication.
// - each port has 8-bit rising, falling and flag registers, bit n for pin n, all reset to zero.
// - flags are set by hardware and also read and written by software, hardware set taking priority.
// - the fourth port implements bit 3 only in all three registers, other bits read zero.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module peci_top (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port1_pins,
   input  wire logic [7:0]  port2_pins,
   input  wire logic [7:0]  port3_pins,
   input  wire logic        port4_pin,
   input  wire logic        sleep_mode,
   output logic             change_irq,
   output logic             wake_req,
   output logic             irq
);

   localparam int NP = peci_pkg::NUM_PORTS;

   // bus state
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        access_w;
   logic        first_w;
   logic        wr_fire_w;

   // per-port register state
   logic [7:0]  rise_en_q [NP];
   logic [7:0]  fall_en_q [NP];
   logic [7:0]  pins_w    [NP];
   logic [7:0]  impl_w    [NP];
   logic [NP-1:0] sel_rise_w;
   logic [NP-1:0] sel_fall_w;
   logic [NP-1:0] sel_flags_w;
   logic [NP-1:0] hit_w;
   logic [NP-1:0] flag_or_w;
   logic [31:0] port_rd_w [NP];

   // control and interrupt state
   logic        master_q;
   logic [peci_pkg::EV_W-1:0] status_q;
   logic [peci_pkg::EV_W-1:0] status_d;
   logic [peci_pkg::EV_W-1:0] status_set_w;
   logic [peci_pkg::EV_W-1:0] status_clr_w;
   logic [peci_pkg::EV_W-1:0] mask_q;
   logic        summary_w;
   logic        edge_any_w;
   logic        wake_d;
   logic        wake_q;
   logic        change_irq_d;
   logic        change_irq_q;
   logic        irq_q;

   // decode of the shared registers
   logic        sel_ctrl_w;
   logic        sel_status_w;
   logic        sel_mask_w;
   logic        sel_port_w;
   logic        mapped_w;
   logic [31:0] ctrl_rd_w;
   logic [31:0] status_rd_w;
   logic [31:0] mask_rd_w;
   logic [31:0] ports_rd_w;
   logic [31:0] rdata_w;

   peci_port_if pif [NP] ();

   // pin vectors; unimplemented pins of the fourth port are tied low
   assign pins_w[0] = port1_pins;
   assign pins_w[1] = port2_pins;
   assign pins_w[2] = port3_pins;
   assign pins_w[3] = {4'h0, port4_pin, 3'h0};

   // APB timing: one wait state, so read data can be registered before pready
   assign access_w  = psel & penable;
   assign first_w   = access_w & ~pready_q;
   assign wr_fire_w = access_w & pready_q & pwrite;

   assign sel_ctrl_w   = (paddr == peci_pkg::ADDR_CTRL);
   assign sel_status_w = (paddr == peci_pkg::ADDR_STATUS);
   assign sel_mask_w   = (paddr == peci_pkg::ADDR_MASK);
   assign sel_port_w   = |{sel_rise_w, sel_fall_w, sel_flags_w};
   assign mapped_w     = sel_ctrl_w | sel_status_w | sel_mask_w | sel_port_w;

   genvar i;
   generate
      for (i = 0; i < NP; i = i + 1)
      begin : g_port
         assign impl_w[i]      = peci_pkg::impl_mask(2'(i));
         assign sel_rise_w[i]  = (paddr == peci_pkg::reg_addr(2'(i), peci_pkg::OFS_RISE));
         assign sel_fall_w[i]  = (paddr == peci_pkg::reg_addr(2'(i), peci_pkg::OFS_FALL));
         assign sel_flags_w[i] = (paddr == peci_pkg::reg_addr(2'(i), peci_pkg::OFS_FLAGS));

         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
            begin
               rise_en_q[i] <= peci_pkg::RST_BYTE;
               fall_en_q[i] <= peci_pkg::RST_BYTE;
            end
            else
            begin
               if (wr_fire_w && sel_rise_w[i])
                  rise_en_q[i] <= pwdata[7:0] & impl_w[i];
               if (wr_fire_w && sel_fall_w[i])
                  fall_en_q[i] <= pwdata[7:0] & impl_w[i];
            end
         end

         assign pif[i].rise_en    = rise_en_q[i];
         assign pif[i].fall_en    = fall_en_q[i];
         assign pif[i].flag_wr    = wr_fire_w & sel_flags_w[i];
         assign pif[i].flag_wdata = pwdata[7:0];

         peci_edge_detect u_edge (
            .clk    (clk),
            .resetn (resetn),
            .pins   (pins_w[i]),
            .rise_o (pif[i].rise_det),
            .fall_o (pif[i].fall_det)
         );

         peci_flag_bank u_bank (
            .clk    (clk),
            .resetn (resetn),
            .impl   (impl_w[i]),
            .pif    (pif[i])
         );

         assign hit_w[i]     = pif[i].hit_any;
         assign flag_or_w[i] = |pif[i].flags;

         // reserved and unimplemented bits read as zero
         assign port_rd_w[i] = sel_rise_w[i]  ? {24'h0, rise_en_q[i]}   :
                               sel_fall_w[i]  ? {24'h0, fall_en_q[i]}   :
                               sel_flags_w[i] ? {24'h0, pif[i].flags}   :
                                                peci_pkg::RST_WORD;
      end
   endgenerate

   // at most one port term is non-zero, so an OR is the selection
   assign ports_rd_w = port_rd_w[0] | port_rd_w[1] | port_rd_w[2] | port_rd_w[3];

   assign summary_w  = |flag_or_w;
   assign edge_any_w = |hit_w;

   assign ctrl_rd_w   = {30'h0, summary_w, master_q};
   assign status_rd_w = {30'h0, status_q};
   assign mask_rd_w   = {30'h0, mask_q};

   assign rdata_w = sel_ctrl_w   ? ctrl_rd_w   :
                    sel_status_w ? status_rd_w :
                    sel_mask_w   ? mask_rd_w   :
                                   ports_rd_w;

   // APB slave
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= peci_pkg::RST_WORD;
      end
      else
      begin
         pready_q  <= first_w;
         pslverr_q <= first_w & ~mapped_w;
         // read data stands only in the answer cycle, a stale word must not linger after it
         if (first_w && !pwrite)
            prdata_q <= rdata_w;
         else
            prdata_q <= peci_pkg::RST_WORD;
      end
   end

   // master enable; the summary bit ignores writes
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         master_q <= 1'b0;
      else if (wr_fire_w && sel_ctrl_w)
         master_q <= pwdata[peci_pkg::CTRL_MASTER];
   end

   // wake is raised in the same cycle the flag becomes visible, never before it
   assign wake_d = sleep_mode & master_q & edge_any_w;

   // request gated by master only, flags keep collecting while it is off
   assign change_irq_d = master_q & summary_w;

   // sticky event bits, write one to clear, a new event beats the clear
   assign status_set_w = {wake_d, edge_any_w};
   assign status_clr_w = (wr_fire_w && sel_status_w) ? pwdata[peci_pkg::EV_W-1:0] :
                                                       peci_pkg::RST_EV;
   assign status_d     = (status_q & ~status_clr_w) | status_set_w;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         status_q     <= peci_pkg::RST_EV;
         mask_q       <= peci_pkg::RST_EV;
         wake_q       <= 1'b0;
         change_irq_q <= 1'b0;
         irq_q        <= 1'b0;
      end
      else
      begin
         status_q     <= status_d;
         if (wr_fire_w && sel_mask_w)
            mask_q <= pwdata[peci_pkg::EV_W-1:0];
         wake_q       <= wake_d;
         change_irq_q <= change_irq_d;
         irq_q        <= |(status_d & mask_q);
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign change_irq = change_irq_q;
   assign wake_req   = wake_q;
   assign irq        = irq_q;

endmodule

/* peci_monitor.sv */
// port-level checks of the edge change interrupt block
`timescale 1ns/10ps
module peci_monitor (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sleep_mode,
   input wire logic        change_irq,
   input wire logic        wake_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence apb_answer;
      (psel && penable && !pready) ##1 (psel && penable && pready);
   endsequence
   wait_state_a: assert property (apb_setup |=> apb_answer)
      else $error("answer not in second access cycle");
   one_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   err_pair_a: assert property (pslverr |-> pready && psel && penable)
      else $error("error without answer");
   unmapped_a: assert property (pready && paddr >= 8'h4C |-> pslverr)
      else $error("unmapped access not refused");
   mapped_a: assert property (pready && paddr == peci_pkg::ADDR_CTRL |-> !pslverr)
      else $error("control access refused");
   wake_sleep_a: assert property (wake_req |-> $past(sleep_mode))
      else $error("wake outside sleep");
   wake_flag_a: assert property (wake_req |=> change_irq)
      else $error("wake without pending request");
   irq_hold_a: assert property ($fell(change_irq) |-> $past(pready && pwrite, 2))
      else $error("request dropped without a write");
endmodule

bind peci_top peci_monitor u_mon (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .sleep_mode, .change_irq, .wake_req);

/* peci_pin_model.sv */
// external levels on the port pins
`timescale 1ns/10ps
module peci_pin_model (
   input  wire logic       clk,
   output logic      [7:0] port1_pins,
   output logic      [7:0] port2_pins,
   output logic      [7:0] port3_pins,
   output logic            port4_pin
);
   initial
   begin
      {port4_pin, port3_pins, port2_pins, port1_pins} = '0;
   end
   // levels held six cycles so the synchroniser never misses a pulse
   task automatic drive(input logic [31:0] lv);
      port1_pins <= lv[7:0];
      port2_pins <= lv[15:8];
      port3_pins <= lv[23:16];
      port4_pin  <= lv[27];
      repeat (6) @(posedge clk);
   endtask
endmodule

/* tb_pin_edge_change_interrupt.sv */
// self-checking bench of the edge change interrupt block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_pin_edge_change_interrupt;
   logic        clk, resetn, psel, penable, pwrite, sleep_mode, mst;
   logic        pready, pslverr, change_irq, wake_req, irq, p4;
   logic [7:0]  paddr, p1, p2, p3;
   logic [31:0] pwdata, prdata, lv_q, fl, re, fe;
   logic [1:0]  st, msk;
   logic [32:0] e_now;
   logic [32:0] exp_q[$];
   int          n_errors, samples_checked, cycles, wakes, w0;

   peci_top dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .port1_pins(p1), .port2_pins(p2), .port3_pins(p3), .port4_pin(p4),
      .sleep_mode, .change_irq, .wake_req, .irq);
   peci_pin_model pins (.clk, .port1_pins(p1), .port2_pins(p2), .port3_pins(p3), .port4_pin(p4));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (wake_req === 1'b1)
         wakes++;
      if (pready === 1'b1)
      begin
         e_now = exp_q.size() ? exp_q.pop_front() : 33'h1FFFFFFFF;
         `CHK("apb answer", e_now, {pslverr, prdata})
      end
      if (cycles > 5000)
      begin
         n_errors++;
         final_report();
      end
   end

   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // the idle edge after release keeps psel from being assigned twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      exp_q.push_back(e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask

   task automatic set_ctl(input logic m);
      wr(peci_pkg::ADDR_CTRL, {30'h0, 1'b1, m});
      mst = m;
      rd(peci_pkg::ADDR_CTRL, {30'h0, |fl, m});
   endtask

   task automatic set_en();
      for (int p = 0; p < 4; p++)
      begin
         wr(8'(p * 16), re >> (p * 8));
         wr(8'(p * 16 + 4), fe >> (p * 8));
      end
      re &= peci_pkg::IMPL_MASKS;
      fe &= peci_pkg::IMPL_MASKS;
      for (int p = 0; p < 4; p++)
      begin
         rd(8'(p * 16), re[p*8 +: 8]);
         rd(8'(p * 16 + 4), fe[p*8 +: 8]);
      end
   endtask

   task automatic edges(input logic [31:0] lv);
      logic [31:0] r;
      r = (lv & ~lv_q & re | ~lv & lv_q & fe) & peci_pkg::IMPL_MASKS;
      fl |= r;
      st[0] |= |r;
      st[1] |= sleep_mode & mst & |r;
      lv_q = lv;
      pins.drive(lv);
   endtask

   task automatic chk_flags();
      for (int p = 0; p < 4; p++)
         rd(8'(p * 16 + 8), fl[p*8 +: 8]);
      `CHK("change_irq", mst & |fl, change_irq)
      `CHK("irq", |(st & msk), irq)
   endtask

   task automatic clr();
      for (int p = 0; p < 4; p++)
         wr(8'(p * 16 + 8), fl[p*8 +: 8] & ~fl[p*8 +: 8]);
      fl = '0;
   endtask

   initial
   begin
      {psel, penable, pwrite, sleep_mode, paddr, pwdata} = '0;
      {lv_q, fl, re, fe, st, msk, mst} = '0;
      resetn = 1'b0;
      void'($urandom(32'hAE864F99));
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
      for (int a = 0; a < 8'h4C; a += 4)
         if (a[3:0] != 4'hC)
            rd(8'(a), 32'h0);
      apb(1'b0, 8'h4C, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 8'h0C, 32'hFF, {1'b1, 32'h0});
      wr(peci_pkg::ADDR_MASK, 32'h3);
      msk = 2'h3;
      set_ctl(1'b1);
      for (int k = 0; k < 4; k++)
      begin
         re = $urandom;
         fe = $urandom;
         set_en();
         edges($urandom);
         edges($urandom);
         chk_flags();
         clr();
      end
      rd(peci_pkg::ADDR_STATUS, {30'h0, st});
      rd(peci_pkg::ADDR_MASK, 32'h3);
      re = '1;
      fe = '1;
      set_en();
      wr(peci_pkg::ADDR_MASK, 32'h0);
      msk = 2'h0;
      edges(~lv_q);
      chk_flags();
      wr(peci_pkg::ADDR_MASK, 32'h3);
      msk = 2'h3;
      chk_flags();
      clr();
      wr(peci_pkg::ADDR_STATUS, 32'h1);
      st[0] = 1'b0;
      chk_flags();
      set_ctl(1'b0);
      edges(~lv_q);
      chk_flags();
      set_ctl(1'b1);
      chk_flags();
      clr();
      edges(lv_q ^ 32'h2);
      fork
         edges(lv_q ^ 32'h1);
         wr(8'h08, 32'h0);
      join
      fl &= ~32'h2;
      chk_flags();
      clr();
      wr(peci_pkg::ADDR_STATUS, 32'h3);
      st = 2'h0;
      sleep_mode <= 1'b1;
      @(posedge clk);
      w0 = wakes;
      edges(lv_q ^ 32'h0800_0000);
      `CHK("wake pulses", 1, wakes - w0)
      sleep_mode <= 1'b0;
      chk_flags();
      rd(peci_pkg::ADDR_STATUS, {30'h0, st});
      final_report();
   end
endmodule
